// file: sipc_ingress_cfg.sv
// Purpose: APB register bank for ingress rules and the priority table.
// Assumes: One clock, synchronous active-high reset, APB3 slave.
// Notes:   Table access takes one cycle; pending is visible for one cycle.

module sipc_ingress_cfg
  import sipc_pkg::*;
#(
  parameter int ENTRIES = 64
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [sipc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    vlanCmdStart,
  input  wire logic [5:0]              lookupIndex,
  output logic      [2:0]              lookupPriority,
  output logic                         echoAllowed,
  output logic      [2:0]              igmpPortMap,
  output logic                         useIpPriority,
  output logic                         igmpMonitorEn,
  output logic                         counterTestMode,
  output logic      [31:0]             counterClearValue,
  output logic                         staticDestPriority,
  output logic                         filterUnknownMcast,
  output logic                         dropUnknownUcast,
  output logic                         usePrecedence,
  output logic                         tagPriorityWins,
  output logic                         vlanEnable
);

  // ****************************************
  // Storage
  // ****************************************
  logic [2:0]     prioTable [ENTRIES];
  logic [7:0]     cmd_r;
  logic [2:0]     wdata_r;
  logic [2:0]     rdata_r;
  logic [2:0]     lookup_r;
  logic [13:0]    glb_r;
  logic [3:0]     vlanCnt_r;
  sipc_state_type state_r;
  sipc_state_type state_nxt;
  logic [31:0]    rdMux;

  // ****************************************
  // APB decode
  // ****************************************
  wire         access    = psel && penable;
  wire         wrAccess  = access && pwrite;
  wire         rdAccess  = access && !pwrite;
  wire         wordAlign = (paddr[1:0] == 2'b00);
  wire  [13:0] wordIdx   = paddr[15:2];
  wire         hitVlan   = wordAlign && (wordIdx == IDX_VLAN_STS);
  wire         hitCmd    = wordAlign && (wordIdx == IDX_PT_CMD);
  wire         hitWdata  = wordAlign && (wordIdx == IDX_PT_WDATA);
  wire         hitRdata  = wordAlign && (wordIdx == IDX_PT_RDATA);
  wire         hitSts    = wordAlign && (wordIdx == IDX_PT_STS);
  wire         hitGlb    = wordAlign && (wordIdx == IDX_GLB_CFG);
  wire         hitAny    = hitVlan | hitCmd | hitWdata | hitRdata
                         | hitSts | hitGlb;
  wire         cmdWrite  = wrAccess && hitCmd;
  wire         ptPending = (state_r != SIPC_IDLE);
  wire         vlanPend  = (vlanCnt_r != 4'h0);
  wire  [5:0]  cmdIdx    = cmd_r[CMD_IDX_HI:0];

  assign pready  = 1'b1;
  assign pslverr = access && !hitAny;

  // Reserved bit 6 reads zero and is not stored
  wire [7:0] cmdWr = {pwdata[CMD_DIR_BIT], 1'b0, pwdata[CMD_IDX_HI:0]};

  // ****************************************
  // Table command sequencer
  // ****************************************
  always_comb begin
    case (state_r)
      SIPC_IDLE: begin
        if (cmdWrite) begin
          state_nxt = pwdata[CMD_DIR_BIT] ? SIPC_READ : SIPC_WRITE;
        end else begin
          state_nxt = SIPC_IDLE;
        end
      end
      SIPC_READ:  state_nxt = SIPC_IDLE;
      SIPC_WRITE: state_nxt = SIPC_IDLE;
      default:    state_nxt = SIPC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= SIPC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Table is not reset, host fills it before use
  always_ff @(posedge clk) begin
    if (state_r == SIPC_WRITE) begin
      prioTable[cmdIdx] <= wdata_r;
    end
  end

  // Forwarding-path lookup port, registered
  always_ff @(posedge clk) begin
    lookup_r <= prioTable[lookupIndex];
  end
  assign lookupPriority = lookup_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= PRIO_RST;
    end else if (state_r == SIPC_READ) begin
      rdata_r <= prioTable[cmdIdx];
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  // Command and write-data writes during a pending access are ignored, protecting the entry
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_r   <= CMD_RST;
      wdata_r <= PRIO_RST;
      glb_r   <= GLB_RST;
    end else begin
      if (cmdWrite && !ptPending) begin
        cmd_r <= cmdWr;
      end
      if (wrAccess && hitWdata && !ptPending) begin
        wdata_r <= pwdata[PRIO_W-1:0];
      end
      if (wrAccess && hitGlb) begin
        glb_r <= pwdata[GLB_W-1:0];
      end
    end
  end

  // VLAN command engine is outside; pending covers a fixed run time
  always_ff @(posedge clk) begin
    if (rst) begin
      vlanCnt_r <= 4'h0;
    end else if (vlanCmdStart) begin
      vlanCnt_r <= VLAN_CMD_CYC;
    end else if (vlanPend) begin
      vlanCnt_r <= vlanCnt_r - 4'h1;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rdMux = 32'h00000000;
    if (hitVlan)  rdMux = {31'h00000000, vlanPend};
    if (hitCmd)   rdMux = {24'h000000, cmd_r};
    if (hitWdata) rdMux = {29'h00000000, wdata_r};
    if (hitRdata) rdMux = {29'h00000000, rdata_r};
    if (hitSts)   rdMux = {31'h00000000, ptPending};
    if (hitGlb)   rdMux = {18'h00000, glb_r};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdMux;
    end else if (rdAccess) begin
      prdata <= prdata;
    end
  end

  // ****************************************
  // Configuration outputs
  // ****************************************
  assign echoAllowed        = glb_r[GLB_ECHO_BIT];
  assign igmpPortMap        = glb_r[GLB_IGMP_PORT_LO+:3];
  assign useIpPriority      = glb_r[GLB_USE_IP_BIT];
  assign igmpMonitorEn      = glb_r[GLB_IGMP_EN_BIT];
  assign counterTestMode    = glb_r[GLB_CNT_TEST_BIT];
  assign counterClearValue  = glb_r[GLB_CNT_TEST_BIT] ? CNT_TEST_LOAD
                            : 32'h00000000;
  assign staticDestPriority = glb_r[GLB_DA_PRIO_BIT];
  assign filterUnknownMcast = glb_r[GLB_FILT_MC_BIT];
  assign dropUnknownUcast   = glb_r[GLB_DROP_UC_BIT];
  assign usePrecedence      = glb_r[GLB_USE_PREC_BIT];
  assign tagPriorityWins    = glb_r[GLB_VL_WINS_BIT];
  assign vlanEnable         = glb_r[GLB_VLAN_EN_BIT];

endmodule : sipc_ingress_cfg

// file: sipc_pkg.sv
// Purpose: Constants for the switch ingress priority configuration block.
// Assumes: APB, 32-bit data, word indexes times four give byte addresses.
// Notes:   Offsets are register indexes; byte address is index * 4.
package sipc_pkg;

  // ****************************************
  // Register indexes and addresses
  // ****************************************
  localparam logic [13:0] IDX_VLAN_STS   = 14'h1810;
  localparam logic [13:0] IDX_PT_CMD     = 14'h1811;
  localparam logic [13:0] IDX_PT_WDATA   = 14'h1812;
  localparam logic [13:0] IDX_PT_RDATA   = 14'h1813;
  localparam logic [13:0] IDX_PT_STS     = 14'h1814;
  localparam logic [13:0] IDX_GLB_CFG    = 14'h1840;
  localparam int          ADDR_W         = 16;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CMD_DIR_BIT      = 7;
  localparam int CMD_IDX_HI       = 5;
  localparam int PRIO_W           = 3;
  localparam int GLB_W            = 14;
  localparam int GLB_ECHO_BIT     = 13;
  localparam int GLB_IGMP_PORT_LO = 10;
  localparam int GLB_USE_IP_BIT   = 9;
  localparam int GLB_RSVD8_BIT    = 8;
  localparam int GLB_IGMP_EN_BIT  = 7;
  localparam int GLB_CNT_TEST_BIT = 6;
  localparam int GLB_DA_PRIO_BIT  = 5;
  localparam int GLB_FILT_MC_BIT  = 4;
  localparam int GLB_DROP_UC_BIT  = 3;
  localparam int GLB_USE_PREC_BIT = 2;
  localparam int GLB_VL_WINS_BIT  = 1;
  localparam int GLB_VLAN_EN_BIT  = 0;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0]  CMD_RST       = 8'h00;
  localparam logic [2:0]  PRIO_RST      = 3'h0;
  localparam logic [13:0] GLB_RST       = 14'h0006;
  localparam logic [31:0] CNT_TEST_LOAD = 32'h7FFFFFFC;
  localparam logic [3:0]  VLAN_CMD_CYC  = 4'h4;

  typedef enum logic [1:0] {
    SIPC_IDLE  = 2'b00,
    SIPC_READ  = 2'b01,
    SIPC_WRITE = 2'b10
  } sipc_state_type;

endpackage : sipc_pkg

// file: sipc_ingress_cfg_assertions.sv
// Purpose: Port-level checks of the ingress configuration register bank.
// Assumes: One clock, synchronous active-high reset, zero-wait APB slave.
// Notes:   Bound to every instance of the top module.
module sipc_ingress_cfg_chk
  import sipc_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_W-1:0]     paddr,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  echoAllowed,
  input wire logic [2:0]            igmpPortMap,
  input wire logic                  counterTestMode,
  input wire logic [31:0]           counterClearValue,
  input wire logic                  usePrecedence,
  input wire logic                  tagPriorityWins,
  input wire logic                  vlanEnable
);
  logic mapped;
  logic glbWr;
  assign mapped = paddr inside {16'h6040, 16'h6044, 16'h6048, 16'h604C,
                                16'h6050, 16'h6100};
  assign glbWr = psel && penable && pwrite && paddr == {IDX_GLB_CFG, 2'h0};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_glb_wr;
    glbWr;
  endsequence
  a_glb_high_bits: assert property (s_glb_wr |=>
    {echoAllowed, igmpPortMap} == $past(pwdata[13:10])) else $error("glb hi");
  a_glb_low_bits: assert property (s_glb_wr |=>
    {counterTestMode, usePrecedence, tagPriorityWins, vlanEnable} ==
    {$past(pwdata[6]), $past(pwdata[2:0])}) else $error("glb lo");
  a_cfg_held: assert property (!glbWr |=>
    $stable({echoAllowed, igmpPortMap, vlanEnable})) else $error("cfg moved");
  a_clear_value: assert property (counterClearValue ==
    (counterTestMode ? 32'h7FFFFFFC : 32'h0)) else $error("clear value");
  a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no pslverr");
  a_mapped_ok: assert property (psel && penable && mapped |->
    pready && !pslverr) else $error("mapped err");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("stray pslverr");
  a_reset_vals: assert property (disable iff (1'b0) rst |=>
    usePrecedence && tagPriorityWins && !vlanEnable) else $error("rst val");
endmodule : sipc_ingress_cfg_chk

bind sipc_ingress_cfg sipc_ingress_cfg_chk u_chk (.clk, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .echoAllowed,
  .igmpPortMap, .counterTestMode, .counterClearValue, .usePrecedence,
  .tagPriorityWins, .vlanEnable);

// file: tb_switch_ingress_priority_config.sv
// Purpose: Directed self-checking bench for the ingress register bank.
// Assumes: Zero-wait APB; table pending clears within a few polls.
// Notes:   Table contents are written before any are read back.
module tb_switch_ingress_priority_config;
  import sipc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, vlanCmdStart = 1'b0, pready, pslverr, err;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, counterClearValue, rd;
  logic [5:0] lookupIndex = 6'h00;
  logic [2:0] lookupPriority, igmpMap;
  logic echo, useIp, igmpEn, cntTest, daPrio, mcF, ucD, prec, vlW, vlE;
  int miscompares = 0, totalChecks = 0;
  localparam logic [15:0] A_VS = {IDX_VLAN_STS, 2'h0};
  localparam logic [15:0] A_CMD = {IDX_PT_CMD, 2'h0};
  localparam logic [15:0] A_WD = {IDX_PT_WDATA, 2'h0};
  localparam logic [15:0] A_RD = {IDX_PT_RDATA, 2'h0};
  localparam logic [15:0] A_TS = {IDX_PT_STS, 2'h0};
  localparam logic [15:0] A_GLB = {IDX_GLB_CFG, 2'h0};
  always #20 clk = ~clk;
  sipc_ingress_cfg DUT (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .vlanCmdStart, .lookupIndex,
    .lookupPriority, .echoAllowed(echo), .igmpPortMap(igmpMap),
    .useIpPriority(useIp), .igmpMonitorEn(igmpEn),
    .counterTestMode(cntTest), .counterClearValue,
    .staticDestPriority(daPrio), .filterUnknownMcast(mcF),
    .dropUnknownUcast(ucD), .usePrecedence(prec),
    .tagPriorityWins(vlW), .vlanEnable(vlE));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk
  // Request held from setup until pready is sampled high
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      $display("[FAIL] pready expected 1 seen %b", pready);
      miscompares++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdchk(input string n, input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rdchk
  task poll();
    int k;
    k = 0;
    do begin
      apb(1'b0, A_TS, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 8);
    chk("tsts", 32'h0, rd);
  endtask : poll
  function automatic logic [2:0] pat(input int i);
    return 3'(i * 3 + 1);
  endfunction : pat
  task t_reset();
    rdchk("glb", A_GLB, 32'h6);
    rdchk("cmd", A_CMD, 32'h0);
    rdchk("wdat", A_WD, 32'h0);
    rdchk("tsts0", A_TS, 32'h0);
    rdchk("vsts0", A_VS, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task t_glb();
    apb(1'b1, A_GLB, 32'hFFFFFFFF);
    rdchk("glb1", A_GLB, 32'h3FFF);
    chk("ctv1", 32'h7FFFFFFC, counterClearValue);
    chk("outs1", 32'h3EFF, {18'h0, echo, igmpMap, useIp, 1'b0, igmpEn,
      cntTest, daPrio, mcF, ucD, prec, vlW, vlE});
    apb(1'b1, A_GLB, 32'h0);
    rdchk("glb0", A_GLB, 32'h0);
    chk("ctv0", 32'h0, counterClearValue);
    chk("outs0", 32'h0, {18'h0, echo, igmpMap, useIp, 1'b0, igmpEn,
      cntTest, daPrio, mcF, ucD, prec, vlW, vlE});
    apb(1'b1, A_GLB, 32'h6);
    $display("global config test done");
  endtask : t_glb
  task t_table();
    for (int i = 0; i < 64; i++) begin
      apb(1'b1, A_WD, {29'h0, pat(i)});
      apb(1'b1, A_CMD, i);
      poll();
    end
    for (int i = 0; i < 64; i++) begin
      apb(1'b1, A_CMD, 32'h80 | i);
      poll();
      rdchk("rdat", A_RD, {29'h0, pat(i)});
      lookupIndex <= i[5:0];
      repeat (2) @(posedge clk);
      chk("lookup", {29'h0, pat(i)}, {29'h0, lookupPriority});
    end
    apb(1'b1, A_CMD, 32'hC5);
    poll();
    rdchk("cmdrb", A_CMD, 32'h85);
    apb(1'b1, A_RD, 32'h7);
    rdchk("rdro", A_RD, {29'h0, pat(5)});
    $display("table test done");
  endtask : t_table
  task t_vlan();
    @(posedge clk);
    vlanCmdStart <= 1'b1;
    @(posedge clk);
    vlanCmdStart <= 1'b0;
    rdchk("vpend", A_VS, 32'h1);
    repeat (6) @(posedge clk);
    apb(1'b1, A_VS, 32'h1);
    rdchk("vdone", A_VS, 32'h0);
    apb(1'b0, 16'h6054, 32'h0);
    chk("uerr", 32'h1, {31'h0, err});
    chk("urd", 32'h0, rd);
    $display("vlan and unmapped test done");
  endtask : t_vlan
  task end_of_test();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_glb();
    t_table();
    t_vlan();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule : tb_switch_ingress_priority_config
